// [hw/slfc_regs.sv]
// LED and forwarding control register bank with frame checks.
// Assumes a 25 MHz core clock, AXI4-Lite master, frame info per cycle.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module slfc_regs #(
  parameter int TICK_CYC = slfc_pkg::BLINK_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [8:0]  port_link_act,
  output logic [8:0]       led_out,
  input  wire logic        frm_valid,
  input  wire logic        frm_crc_ok,
  input  wire logic [15:0] frm_len_field,
  input  wire logic [15:0] frm_data_octets,
  input  wire logic [3:0]  frm_ingress,
  input  wire logic        frm_addr_miss,
  input  wire logic        frm_mcast,
  input  wire logic [8:0]  frm_egress_in,
  output logic             frm_done,
  output logic             frm_drop,
  output logic             frm_len_mism,
  output logic             frm_len_gap,
  output logic             frm_use_miss_map,
  output logic [8:0]       frm_egress_out
);

  localparam int N = slfc_pkg::PORT_N;
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0] led_en_q, mode_lo_q, mode_hi_q, prot_q;
  logic [7:0]  fwd_q;
  logic [2:0]  blink_q;
  logic [9:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [8:0]  led_q, egress_q, led_d;
  logic        done_q, drop_q, mism_q, gap_q, map_q;
  logic        blink_phase;
  // ****************************************************************
  // Write channel acceptance and decode
  // ****************************************************************
  wire [7:0]  wr_idx   = awaddr_q[9:2];
  wire        wr_go    = aw_held_q && w_held_q && !bvalid_q;
  wire        wr_en_h  = wr_idx == slfc_pkg::IDX_LED_EN;
  wire        wr_lo_h  = wr_idx == slfc_pkg::IDX_MODE_LO;
  wire        wr_hi_h  = wr_idx == slfc_pkg::IDX_MODE_HI;
  wire        wr_fc_h  = wr_idx == slfc_pkg::IDX_FWD_CTRL;
  wire        wr_pr_h  = wr_idx == slfc_pkg::IDX_PROT_SEL;
  wire        wr_bl_h  = wr_idx == slfc_pkg::IDX_BLINK;
  wire        wr_st_h  = wr_idx == slfc_pkg::IDX_STATUS;
  wire        wr_hit   = wr_en_h | wr_lo_h | wr_hi_h | wr_fc_h |
                         wr_pr_h | wr_bl_h | wr_st_h;
  wire [31:0] bmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                          {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wd_m     = wdata_q & bmask;
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  // Address and data are held until both are here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 10'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response, error for an unmapped word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= slfc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? slfc_pkg::RESP_OKAY : slfc_pkg::RESP_SLV;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  // ****************************************************************
  // Register updates, byte lanes honoured
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_en_q  <= slfc_pkg::RST_LED_EN;
      mode_lo_q <= slfc_pkg::RST_MODE;
      mode_hi_q <= slfc_pkg::RST_MODE;
      fwd_q     <= slfc_pkg::RST_FWD_CTRL;
      prot_q    <= slfc_pkg::RST_PROT_SEL;
      blink_q   <= slfc_pkg::RST_BLINK;
    end else if (wr_go) begin
      if (wr_en_h) led_en_q  <= (led_en_q & ~bmask[15:0]) | wd_m[15:0];
      if (wr_lo_h) mode_lo_q <= (mode_lo_q & ~bmask[15:0]) | wd_m[15:0];
      if (wr_hi_h) mode_hi_q <= (mode_hi_q & ~bmask[15:0]) | wd_m[15:0];
      if (wr_fc_h) fwd_q     <= (fwd_q & ~bmask[7:0]) | wd_m[7:0];
      if (wr_pr_h) prot_q    <= ((prot_q & ~bmask[15:0]) | wd_m[15:0])
                                & slfc_pkg::PROT_MASK;
      if (wr_bl_h) blink_q   <= (blink_q & ~bmask[2:0]) | wd_m[2:0];
    end
  end
  // ****************************************************************
  // Read channel
  // ****************************************************************
  wire [7:0]  rd_idx  = s_axi_araddr[9:2];
  wire [31:0] status  = {25'h0, blink_phase, done_q, drop_q, mism_q,
                         gap_q, map_q, 1'b0};
  wire        rd_en_h = rd_idx == slfc_pkg::IDX_LED_EN;
  wire        rd_lo_h = rd_idx == slfc_pkg::IDX_MODE_LO;
  wire        rd_hi_h = rd_idx == slfc_pkg::IDX_MODE_HI;
  wire        rd_fc_h = rd_idx == slfc_pkg::IDX_FWD_CTRL;
  wire        rd_pr_h = rd_idx == slfc_pkg::IDX_PROT_SEL;
  wire        rd_bl_h = rd_idx == slfc_pkg::IDX_BLINK;
  wire        rd_st_h = rd_idx == slfc_pkg::IDX_STATUS;
  wire        rd_hit  = rd_en_h | rd_lo_h | rd_hi_h | rd_fc_h |
                        rd_pr_h | rd_bl_h | rd_st_h;
  wire [31:0] rd_mux  =
    ({32{rd_en_h}} & {16'h0, led_en_q})  |
    ({32{rd_lo_h}} & {16'h0, mode_lo_q}) |
    ({32{rd_hi_h}} & {16'h0, mode_hi_q}) |
    ({32{rd_fc_h}} & {24'h0, fwd_q})     |
    ({32{rd_pr_h}} & {16'h0, prot_q})    |
    ({32{rd_bl_h}} & {29'h0, blink_q})   |
    ({32{rd_st_h}} & status);

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Read data captured on address acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= slfc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? slfc_pkg::RESP_OKAY : slfc_pkg::RESP_SLV;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  // ****************************************************************
  // LED drive
  // ****************************************************************
  slfc_blink #(
    .TICK_CYC   (TICK_CYC)
  ) u_blink (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .period_sel (blink_q),
    .phase      (blink_phase)
  );

  // Per-port mode decode, high bit over low bit
  for (genvar i = 0; i < N; i++) begin : g_led
    wire [1:0] mode = {mode_hi_q[i], mode_lo_q[i]};
    assign led_d[i] = led_en_q[i] &&
      ((mode == slfc_pkg::MODE_ON)    ||
       ((mode == slfc_pkg::MODE_BLINK) && blink_phase) ||
       ((mode == slfc_pkg::MODE_AUTO)  && port_link_act[i]));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) led_q <= 9'h000;
    else          led_q <= led_d;
  end
  assign led_out = led_q;
  // ****************************************************************
  // Frame classification and forwarding
  // ****************************************************************
  wire in_win   = (frm_len_field >= slfc_pkg::LEN_MIN) &&
                  (frm_len_field <= slfc_pkg::LEN_MAX);
  wire mism_d   = frm_crc_ok &&
    ((in_win && (frm_len_field != frm_data_octets)) ||
     ((frm_len_field < slfc_pkg::LEN_MIN) &&
      (frm_data_octets > slfc_pkg::LEN_MIN)));
  wire gap_d    = frm_crc_ok &&
    (frm_len_field > slfc_pkg::LEN_MAX) &&
    (frm_len_field < slfc_pkg::LEN_TYPE);
  wire drop_d   = (fwd_q[slfc_pkg::FC_LEN_MISM] && mism_d) ||
                  (fwd_q[slfc_pkg::FC_LEN_GAP] && gap_d);
  wire map_d    = frm_addr_miss &&
    (frm_mcast ? fwd_q[slfc_pkg::FC_MCAST_MAP]
               : fwd_q[slfc_pkg::FC_UCAST_MAP]);
  wire ing_prot = (frm_ingress < slfc_pkg::PORT_CNT) &&
                  prot_q[frm_ingress];
  wire [8:0] eg_d = ing_prot ? (frm_egress_in & ~prot_q[8:0])
                             : frm_egress_in;

  // Results are captured per offered frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q   <= 1'b0;
      drop_q   <= 1'b0;
      mism_q   <= 1'b0;
      gap_q    <= 1'b0;
      map_q    <= 1'b0;
      egress_q <= 9'h000;
    end else begin
      done_q <= frm_valid;
      if (frm_valid) begin
        drop_q   <= drop_d;
        mism_q   <= mism_d;
        gap_q    <= gap_d;
        map_q    <= map_d;
        egress_q <= eg_d;
      end
    end
  end

  assign frm_done         = done_q;
  assign frm_drop         = drop_q;
  assign frm_len_mism     = mism_q;
  assign frm_len_gap      = gap_q;
  assign frm_use_miss_map = map_q;
  assign frm_egress_out   = egress_q;
  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire [8:0] on_m   = led_en_q[8:0] & ~mode_hi_q[8:0] & mode_lo_q[8:0];
  wire [8:0] off_m  = ~mode_hi_q[8:0] & ~mode_lo_q[8:0];
  wire [8:0] auto_m = led_en_q[8:0] & mode_hi_q[8:0] & mode_lo_q[8:0];
  sequence s_frame_gap;
    frm_valid && frm_crc_ok && fwd_q[slfc_pkg::FC_LEN_GAP] &&
    (frm_len_field > slfc_pkg::LEN_MAX) &&
    (frm_len_field < slfc_pkg::LEN_TYPE);
  endsequence
  sequence s_frame_prot;
    frm_valid && ing_prot;
  endsequence
  a_led_disabled_dark: assert property (
    ##1 ((led_out & ~$past(led_en_q[8:0])) == 9'h000))
    else $error("disabled LED lit");
  a_led_on_off_code: assert property (
    ##1 (((led_out & $past(off_m)) == 9'h000) &&
         ((~led_out & $past(on_m)) == 9'h000)))
    else $error("LED on or off code not obeyed");
  a_led_auto_follow: assert property (
    ##1 (((led_out ^ $past(port_link_act)) & $past(auto_m)) == 9'h000))
    else $error("auto LED not following activity");
  a_regs_reset_vals: assert property (
    $past(!aresetn) |-> (led_en_q == slfc_pkg::RST_LED_EN) &&
      (mode_hi_q == slfc_pkg::RST_MODE) && (prot_q == 16'h0000))
    else $error("register reset value wrong");
  a_prot_upper_zero: assert property (
    (prot_q & ~slfc_pkg::PROT_MASK) == 16'h0000)
    else $error("protected select upper bits not zero");
  a_len_mism_flag: assert property (
    frm_valid && frm_crc_ok && in_win &&
    (frm_len_field != frm_data_octets) |=> frm_len_mism ##0 frm_done)
    else $error("length mismatch not flagged");
  a_len_mism_drop: assert property (
    frm_valid && fwd_q[slfc_pkg::FC_LEN_MISM] && mism_d |=> frm_drop)
    else $error("length mismatch frame not dropped");
  a_len_gap_drop: assert property (
    s_frame_gap |=> frm_drop && frm_len_gap)
    else $error("length gap frame not dropped");
  a_len_gap_edges: assert property (
    frm_valid && ((frm_len_field == slfc_pkg::LEN_MAX) ||
      (frm_len_field == slfc_pkg::LEN_TYPE)) |=> !frm_len_gap)
    else $error("length gap edge misclassified");
  a_prot_block_pair: assert property (
    s_frame_prot |=> ((frm_egress_out & $past(prot_q[8:0])) == 9'h000))
    else $error("protected pair forwarded");
  a_unprot_pass: assert property (
    frm_valid && !ing_prot |=> frm_egress_out == $past(frm_egress_in))
    else $error("unprotected port restricted");
  a_miss_map_mcast: assert property (
    frm_valid && frm_addr_miss && frm_mcast |=>
      frm_use_miss_map == $past(fwd_q[slfc_pkg::FC_MCAST_MAP]))
    else $error("multicast miss forward choice wrong");
  a_miss_map_ucast: assert property (
    frm_valid && frm_addr_miss && !frm_mcast |=>
      frm_use_miss_map == $past(fwd_q[slfc_pkg::FC_UCAST_MAP]))
    else $error("unicast miss forward choice wrong");
  a_write_resp_time: assert property (
    aw_held_q && w_held_q && !bvalid_q |=> s_axi_bvalid)
    else $error("write response late");
endmodule // slfc_regs

// [hw/slfc_pkg.sv]
// Constants for the switch LED and forwarding control register bank.
// Assumes a 25 MHz core clock and a 32-bit AXI4-Lite register port.
package slfc_pkg;

  // ****************************************************************
  // Geometry and clock
  // ****************************************************************
  localparam int          PORT_N      = 9;
  localparam logic [3:0]  PORT_CNT    = 4'h9;
  localparam int          CLK_HZ      = 25_000_000;
  localparam int          BLINK_MS    = 10;
  localparam int          BLINK_CYC   = CLK_HZ / 1000 * BLINK_MS;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [7:0]  IDX_LED_EN   = 8'h16;
  localparam logic [7:0]  IDX_MODE_LO  = 8'h18;
  localparam logic [7:0]  IDX_MODE_HI  = 8'h1A;
  localparam logic [7:0]  IDX_FWD_CTRL = 8'h21;
  localparam logic [7:0]  IDX_PROT_SEL = 8'h24;
  localparam logic [7:0]  IDX_BLINK    = 8'h0F;
  localparam logic [7:0]  IDX_STATUS   = 8'h30;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [15:0] RST_LED_EN   = 16'h001F;
  localparam logic [15:0] RST_MODE     = 16'h01FF;
  localparam logic [7:0]  RST_FWD_CTRL = 8'h01;
  localparam logic [15:0] RST_PROT_SEL = 16'h0000;
  localparam logic [2:0]  RST_BLINK    = 3'h3;
  localparam int          FC_MCAST_MAP = 7;
  localparam int          FC_UCAST_MAP = 6;
  localparam int          FC_LEN_MISM  = 2;
  localparam int          FC_LEN_GAP   = 1;
  localparam logic [15:0] PROT_MASK    = 16'h01FF;

  // ****************************************************************
  // LED mode codes, length limits, bus answers
  // ****************************************************************
  localparam logic [1:0]  MODE_OFF   = 2'h0;
  localparam logic [1:0]  MODE_ON    = 2'h1;
  localparam logic [1:0]  MODE_BLINK = 2'h2;
  localparam logic [1:0]  MODE_AUTO  = 2'h3;
  localparam logic [15:0] LEN_MIN    = 16'h002E;
  localparam logic [15:0] LEN_MAX    = 16'h05DC;
  localparam logic [15:0] LEN_TYPE   = 16'h0600;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;

endpackage

// [hw/slfc_blink.sv]
// Blink phase generator for the port LEDs.
// Assumes the period select is a register of the parent bank.
`timescale 1ns/1ns
module slfc_blink #(
  parameter int TICK_CYC = slfc_pkg::BLINK_CYC
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] period_sel,
  output logic            phase
);

  logic [31:0] tick_q;
  logic [2:0]  unit_q;
  logic        phase_q;
  wire         tick_end;
  wire  [2:0]  unit_lim;
  wire         unit_end;

  // ****************************************************************
  // Ten millisecond tick and unit counter
  // ****************************************************************
  // Code zero is reserved and runs like code one
  assign tick_end = (tick_q == 32'(TICK_CYC - 1));
  assign unit_lim = (period_sel == 3'h0) ? 3'h1 : period_sel;
  assign unit_end = tick_end && (unit_q >= unit_lim);
  assign phase    = phase_q;

  // Phase flips once per (N + 1) ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q  <= 32'h0;
      unit_q  <= 3'h0;
      phase_q <= 1'b0;
    end else begin
      tick_q  <= tick_end ? 32'h0 : tick_q + 32'h1;
      if (unit_end) begin
        unit_q  <= 3'h0;
        phase_q <= ~phase_q;
      end else if (tick_end) begin
        unit_q  <= unit_q + 3'h1;
      end
    end
  end

endmodule // slfc_blink

// [sim/tb_top.sv]
// Self-checking testbench for the LED and forwarding control bank.
// Assumes slfc_pkg and slfc_regs are compiled first; bench is the master.
`timescale 1ns/1ns
module tb_top;
  // ************************************************************
  // Signals and design instance
  // ************************************************************
  localparam int TICK = 4;
  localparam logic [9:0]  RA [6] = '{10'h058, 10'h060, 10'h068,
                                     10'h084, 10'h090, 10'h03C};
  localparam logic [31:0] RV [6] = '{32'h1F, 32'h1FF, 32'h1FF,
                                     32'h01, 32'h00, 32'h03};
  localparam logic [15:0] CL [6] = '{16'h002D, 16'h002E, 16'h05DC,
                                     16'h05DD, 16'h05FF, 16'h0600};
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed, rd;
  logic [1:0]  bresp, rresp, rsp;
  logic [8:0]  link_act, led_out, eg_in, eg_out, prot_v, en_v, lo_v, hi_v;
  logic        f_valid, f_crc, f_miss, f_mc, f_done, f_drop, f_mism, f_gap;
  logic        f_map;
  logic [15:0] f_len, f_oct;
  logic [3:0]  f_ing;
  logic [7:0]  ctrl_v;
  int          fails, n_checks, cnt, per;

  slfc_regs #(.TICK_CYC(TICK)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_link_act(link_act),
    .led_out(led_out), .frm_valid(f_valid), .frm_crc_ok(f_crc),
    .frm_len_field(f_len), .frm_data_octets(f_oct), .frm_ingress(f_ing),
    .frm_addr_miss(f_miss), .frm_mcast(f_mc), .frm_egress_in(eg_in),
    .frm_done(f_done), .frm_drop(f_drop), .frm_len_mism(f_mism),
    .frm_len_gap(f_gap), .frm_use_miss_map(f_map), .frm_egress_out(eg_out)
  );

  // ************************************************************
  // Helpers: random source, compare, bus cycles
  // ************************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Write with address and data offered together; waits for the answer
  task automatic wr(input logic [9:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic sa, sw, sb;
    int   n;
    sb = 1'b0;
    n = 0;
    r = 2'h3;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    while (!sb && n < 200) begin
      @(negedge aclk);
      sa = awready & awvalid; sw = wready & wvalid; sb = bvalid; r = bresp;
      @(posedge aclk);
      if (sa) awvalid <= 1'b0;
      if (sw) wvalid <= 1'b0;
      n++;
    end
    if (!sb) chk(32'h0, 32'h1, "write answer missing");
  endtask

  // Read one word; waits for rvalid
  task automatic rdw(input logic [9:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic sa, sr;
    int   n;
    sr = 1'b0;
    n = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!sr && n < 200) begin
      @(negedge aclk);
      sa = arready & arvalid; sr = rvalid; d = rdata; r = rresp;
      @(posedge aclk);
      if (sa) arvalid <= 1'b0;
      n++;
    end
    if (!sr) chk(32'h0, 32'h1, "read answer missing");
  endtask

  function automatic logic [8:0] led_exp(input logic [8:0] act);
    logic [8:0] e;
    for (int i = 0; i < 9; i++) begin
      case ({hi_v[i], lo_v[i]})
        2'h1:    e[i] = en_v[i];
        2'h3:    e[i] = en_v[i] & act[i];
        default: e[i] = 1'b0;
      endcase
    end
    return e;
  endfunction

  // One frame with random side fields; checks results a cycle later
  task automatic frame(input logic [15:0] len, input logic [15:0] oct);
    logic [31:0] x;
    logic        crc, mism, gap, prt, drp, mp;
    logic [8:0]  eg;
    logic [3:0]  ing;
    x = xs();
    crc = x[0] | x[1];
    ing = 4'(x[11:4] % 10);
    mism = crc && ((len >= 16'h002E && len <= 16'h05DC && len != oct) ||
                   (len < 16'h002E && oct > 16'h002E));
    gap = crc && len > 16'h05DC && len < 16'h0600;
    prt = (ing < 4'h9) && prot_v[ing];
    drp = (ctrl_v[2] & mism) | (ctrl_v[1] & gap);
    mp = x[12] & (x[13] ? ctrl_v[7] : ctrl_v[6]);
    eg = prt ? x[22:14] & ~prot_v : x[22:14];
    f_valid <= 1'b1; f_len <= len; f_oct <= oct; f_crc <= crc;
    f_ing <= ing; f_miss <= x[12]; f_mc <= x[13]; eg_in <= x[22:14];
    @(posedge aclk);
    f_valid <= 1'b0;
    @(negedge aclk);
    chk(32'(f_done), 32'h1, "frame done");
    chk(32'({f_mism, f_gap}), 32'({mism, gap}), "class");
    chk(32'(f_drop), 32'(drp), "drop");
    chk(32'(f_map), 32'(mp), "miss map");
    chk(32'(eg_out), 32'(eg), "egress");
    @(posedge aclk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // Clock, watchdog and main sequence
  // ************************************************************
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Cuts a hang short well past the expected run length
  initial begin
    #(40 * 30000);
    fails++;
    summarize();
  end

  initial begin
    seed = 32'h8005; fails = 0; n_checks = 0; aresetn = 1'b0;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = '0; araddr = '0; wdata = '0; link_act = '0; f_valid = 0;
    f_crc = 0; f_miss = 0; f_mc = 0; f_len = '0; f_oct = '0; f_ing = '0;
    eg_in = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) begin
      rdw(RA[i], rd, rsp);
      chk(rd, RV[i], "reset value");
    end
    wr(10'h100, 32'hFFFF, rsp);
    chk(32'(rsp), 32'h2, "unmapped write");
    rdw(10'h104, rd, rsp);
    chk(rd, 32'h0, "unmapped read data");
    chk(32'(rsp), 32'h2, "unmapped read answer");
    wr(10'h090, 32'hFFFF, rsp);
    rdw(10'h090, rd, rsp);
    chk(rd, 32'h1FF, "protected upper bits");
    // LED modes and enables with random maps and activity
    for (int k = 0; k < 12; k++) begin
      en_v = 9'(xs()); lo_v = 9'(xs()); hi_v = 9'(xs());
      wr(10'h058, {23'h0, en_v}, rsp);
      wr(10'h060, {23'h0, lo_v}, rsp);
      wr(10'h068, {23'h0, hi_v}, rsp);
      for (int j = 0; j < 2; j++) begin
        link_act <= 9'(xs());
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk(32'(led_out & ~(hi_v & ~lo_v & en_v)), 32'(led_exp(link_act)),
            "led");
        @(posedge aclk);
      end
    end
    // Blink rate for several period selects
    en_v = 9'h1FF;
    wr(10'h058, 32'h1FF, rsp);
    wr(10'h060, 32'h0, rsp);
    wr(10'h068, 32'h1FF, rsp);
    for (int n = 0; n < 8; n = n * 2 + 1) begin
      wr(10'h03C, 32'(n), rsp);
      cnt = 0;
      per = TICK * (n + 1 + int'(n == 0));
      repeat (128) begin
        @(negedge aclk);
        rd[0] = led_out[0];
        @(posedge aclk);
        #1;
        if (led_out[0] !== rd[0]) cnt++;
      end
      chk(32'(cnt >= 128 / per - 1 && cnt <= 128 / per + 1), 32'h1,
          "blink");
      @(posedge aclk);
    end
    // Frame checks under random forward control and protection
    for (int k = 0; k < 5; k++) begin
      ctrl_v = 8'(xs()) | 8'h01; prot_v = 9'(xs());
      wr(10'h084, {24'h0, ctrl_v}, rsp);
      wr(10'h090, {23'h0, prot_v}, rsp);
      for (int i = 0; i < 6; i++) frame(CL[i], i[0] ? CL[i] : 16'h002F);
      for (int i = 0; i < 12; i++) begin
        rd = xs();
        frame(16'(rd[15:0] % 1600), rd[16] ? 16'(rd[15:0] % 1600)
                                           : 16'(rd[31:17] % 1600));
      end
    end
    // Status word is read-only and mirrors the last frame results
    wr(10'h0C0, 32'hFF, rsp);
    chk(32'(rsp), 32'h0, "status write answer");
    rdw(10'h0C0, rd, rsp);
    chk({26'h0, rd[5:0]}, {27'h0, f_drop, f_mism, f_gap, f_map, 1'b0},
        "status");
    summarize();
  end
endmodule // tb_top
